// ### src/adc_swap_dither_timestamp_ctrl.sv
// Swap select delay, dither, marker and link enable registers on AHB-Lite
// Notes on behaviour
// - Five-bit swap delay, resets to seven
// - Delay accepts every value zero to 31
// - Delay applies only during core swaps
// - Delayed select steers core data to encoders
// - Dither bit zero enables dither
// - Dither bit one picks large amplitude
// - Dither bit two picks rounding error sink
// - Marker enable puts timestamp on LSB
// - Marker latency matches analog sample path
// - Marker at N-field LSB, sample untouched
// - Lane alignment reports control bits zero
// - Link enable at 0x200, resets enabled
`timescale 1ns/1ps
module adc_swap_dither_timestamp_ctrl
  import swap_ctrl_pkg::*;
#(
  parameter int CONV_W = 12,
  parameter int N_W = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic swap_active,
  input wire logic swap_sel_raw,
  input wire core_pair_t core_data,
  input wire logic marker_in,
  output logic [CONV_W-1:0] encoder_data,
  output logic [N_W-1:0] transport_sample,
  output dither_cfg_t dither_cfg,
  output logic serial_link_subsystem_on,
  output logic [1:0] ila_control_bits
);
  logic [7:0] swap_dly_r;
  logic [7:0] dither_r;
  logic [7:0] marker_r;
  logic [7:0] link_en_r;
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic sel_dly;
  logic [CONV_W-1:0] steer_nxt;
  logic [7:0] rd_nxt;
  logic [31:0] mapped_rd;
  logic addr_phase;

  // Marker needs a spare bit below the sample in the transport field
  if (N_W <= CONV_W)
  begin : g_width_chk
    $error("adc_swap_dither_timestamp_ctrl: N_W must exceed CONV_W");
  end

  assign addr_phase = hsel && hready && htrans[1];

  // Write data phase follows the address phase by one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite;
      if (addr_phase)
        wr_addr_r <= haddr[13:2];
    end
  end

  // Register writes; unwritable bits of each byte are kept zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      swap_dly_r <= RST_SWAP_DLY;
      dither_r <= RST_DITHER;
      marker_r <= RST_MARKER;
      link_en_r <= RST_LINK_EN;
    end
    else if (wr_pend_r)
    begin
      case (wr_addr_r)
        OFF_SWAP_DLY: swap_dly_r <= hwdata[7:0] & SWAP_DLY_MASK;
        OFF_DITHER: dither_r <= hwdata[7:0] & DITHER_MASK;
        OFF_MARKER: marker_r <= hwdata[7:0] & MARKER_MASK;
        OFF_LINK_EN: link_en_r <= hwdata[7:0] & LINK_EN_MASK;
        default: ;
      endcase
    end
  end

  // Word decode: each register sits at four times its offset
  always_comb
  begin
    case (haddr[13:2])
      OFF_SWAP_DLY: rd_nxt = swap_dly_r;
      OFF_DITHER: rd_nxt = dither_r;
      OFF_MARKER: rd_nxt = marker_r;
      OFF_LINK_EN: rd_nxt = link_en_r;
      OFF_ILA_CS: rd_nxt = {6'h00, ILA_CS_VALUE};
      default: rd_nxt = 8'h00;
    endcase
  end
  assign mapped_rd = {24'h000000, rd_nxt};

  // Zero wait states; read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite)
        hrdata <= mapped_rd;
    end
  end

  select_delay_line #(
    .DEPTH(DLY_MAX + 1)
  ) u_dly (
    .hclk(hclk),
    .hresetn(hresetn),
    .swap_active(swap_active),
    .sel_raw(swap_sel_raw),
    .delay(swap_dly_r[DLY_W-1:0]),
    .sel_out(sel_dly)
  );

  assign steer_nxt = sel_dly ? core_data.core_b : core_data.core_a;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      encoder_data <= '0;
    else
      encoder_data <= steer_nxt;
  end

  marker_inserter #(
    .CONV_W(CONV_W),
    .N_W(N_W)
  ) u_mark (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_in(encoder_data),
    .marker_in(marker_in),
    .enable(marker_r[MARKER_EN_BIT]),
    .sample_out(transport_sample)
  );

  // Dither options follow the register one cycle later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dither_cfg <= '0;
    else
    begin
      dither_cfg.dither_enable_bit <= dither_r[DITH_EN_BIT];
      dither_cfg.dither_amplitude_select <= dither_r[DITH_AMP_BIT];
      dither_cfg.dither_rounding_choice <= dither_r[DITH_ERR_BIT];
    end
  end

  // Link subsystem comes up enabled
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      serial_link_subsystem_on <= RST_LINK_EN[LINK_ON_BIT];
    else
      serial_link_subsystem_on <= link_en_r[LINK_ON_BIT];
  end

  // Lane alignment never advertises the marker bit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ila_control_bits <= ILA_CS_VALUE;
    else
      ila_control_bits <= ILA_CS_VALUE;
  end

  chk_delay_range: assert property (@(posedge hclk) disable iff (!hresetn)
    swap_dly_r[7:5] == 3'h0)
    else $error("swap delay reserved bits set");

  chk_idle_no_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn && !swap_active |=> sel_dly == $past(swap_sel_raw))
    else $error("select delayed outside swap");

  sequence s_dly_write;
    wr_pend_r && wr_addr_r == OFF_SWAP_DLY;
  endsequence
  chk_delay_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dly_write |=> swap_dly_r == ($past(hwdata[7:0]) & SWAP_DLY_MASK))
    else $error("swap delay not stored");

  chk_dither_enable: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 dither_cfg.dither_enable_bit == $past(dither_r[0]))
    else $error("dither enable mismatch");

  chk_dither_amp: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 dither_cfg.dither_amplitude_select == $past(dither_r[1]))
    else $error("dither amplitude mismatch");

  chk_dither_round: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 dither_cfg.dither_rounding_choice == $past(dither_r[2]))
    else $error("dither rounding mismatch");

  chk_marker_lsb: assert property (@(posedge hclk) disable iff (!hresetn)
    marker_r[0] |=> transport_sample[0] == $past(marker_in))
    else $error("marker not on LSB");

  chk_sample_kept: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 transport_sample[N_W-1 -: CONV_W] == $past(encoder_data))
    else $error("sample bits altered");

  chk_steer_route: assert property (@(posedge hclk) disable iff (!hresetn)
    hresetn |=> encoder_data ==
      ($past(sel_dly) ? $past(core_data.core_b) : $past(core_data.core_a)))
    else $error("steering mismatch");

  chk_ila_cs_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ila_control_bits == 2'h0)
    else $error("ILA control bits nonzero");

  chk_link_follow: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_pend_r && wr_addr_r == OFF_LINK_EN |=> ##1 serial_link_subsystem_on == $past(hwdata[0], 2))
    else $error("link enable not applied");

  sequence s_dither_write;
    wr_pend_r && wr_addr_r == OFF_DITHER;
  endsequence
  chk_dither_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dither_write |=> dither_r == ($past(hwdata[7:0]) & DITHER_MASK))
    else $error("dither register not stored");

  sequence s_marker_write;
    wr_pend_r && wr_addr_r == OFF_MARKER;
  endsequence
  chk_marker_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_marker_write |=> marker_r == ($past(hwdata[7:0]) & MARKER_MASK))
    else $error("marker register not stored");

  sequence s_link_write;
    wr_pend_r && wr_addr_r == OFF_LINK_EN;
  endsequence
  chk_link_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    s_link_write |=> link_en_r == ($past(hwdata[7:0]) & LINK_EN_MASK))
    else $error("link enable register not stored");

  chk_dly_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend_r && wr_addr_r == OFF_SWAP_DLY) |=> $stable(swap_dly_r))
    else $error("swap delay changed without write");

  sequence s_swap_dly_zero;
    swap_active && swap_dly_r[DLY_W-1:0] == 5'd0;
  endsequence
  chk_swap_dly_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s_swap_dly_zero |=> sel_dly == $past(swap_sel_raw))
    else $error("zero swap delay not one cycle");

  sequence s_swap_dly_five;
    swap_active && swap_dly_r[DLY_W-1:0] == 5'd5;
  endsequence
  chk_swap_dly_five: assert property (@(posedge hclk) disable iff (!hresetn)
    s_swap_dly_five |=> sel_dly == $past(swap_sel_raw, 6))
    else $error("swap delay of five not applied");

  sequence s_swap_dly_max;
    swap_active && swap_dly_r[DLY_W-1:0] == 5'd31;
  endsequence
  chk_swap_dly_max: assert property (@(posedge hclk) disable iff (!hresetn)
    s_swap_dly_max |=> sel_dly == $past(swap_sel_raw, 32))
    else $error("largest swap delay not applied");

  chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not ready and okay");

  sequence s_dly_read;
    addr_phase && !hwrite && haddr[13:2] == OFF_SWAP_DLY;
  endsequence
  chk_read_dly: assert property (@(posedge hclk) disable iff (!hresetn)
    s_dly_read |=> hrdata == {24'h000000, $past(swap_dly_r)})
    else $error("swap delay read data wrong");

  chk_marker_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !marker_r[MARKER_EN_BIT] |=> transport_sample[0] == 1'b0)
    else $error("marker present while disabled");
endmodule : adc_swap_dither_timestamp_ctrl

// ### src/swap_ctrl_pkg.sv
// Package: register map, field layout, reset values and datapath structs
package swap_ctrl_pkg;
  localparam logic [11:0] OFF_SWAP_DLY = 12'h09b;
  localparam logic [11:0] OFF_DITHER = 12'h09d;
  localparam logic [11:0] OFF_MARKER = 12'h160;
  localparam logic [11:0] OFF_LINK_EN = 12'h200;
  localparam logic [11:0] OFF_ILA_CS = 12'h204;
  localparam logic [7:0] RST_SWAP_DLY = 8'h07;
  localparam logic [7:0] RST_DITHER = 8'h00;
  localparam logic [7:0] RST_MARKER = 8'h00;
  localparam logic [7:0] RST_LINK_EN = 8'h01;
  localparam logic [1:0] ILA_CS_VALUE = 2'h0;
  localparam int DLY_W = 5;
  localparam int DLY_MAX = 31;
  localparam int DITH_EN_BIT = 0;
  localparam int DITH_AMP_BIT = 1;
  localparam int DITH_ERR_BIT = 2;
  localparam int MARKER_EN_BIT = 0;
  localparam int LINK_ON_BIT = 0;
  localparam logic [7:0] SWAP_DLY_MASK = 8'h1f;
  localparam logic [7:0] DITHER_MASK = 8'h07;
  localparam logic [7:0] MARKER_MASK = 8'h01;
  localparam logic [7:0] LINK_EN_MASK = 8'h01;

  typedef struct packed {
    logic dither_enable_bit;
    logic dither_amplitude_select;
    logic dither_rounding_choice;
  } dither_cfg_t;

  typedef struct packed {
    logic [11:0] core_a;
    logic [11:0] core_b;
  } core_pair_t;
endpackage : swap_ctrl_pkg

// ### src/select_delay_line.sv
// Programmable delay of the core steering select during swaps
`timescale 1ns/1ps
module select_delay_line
  import swap_ctrl_pkg::*;
#(
  parameter int DEPTH = DLY_MAX + 1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic swap_active,
  input wire logic sel_raw,
  input wire logic [DLY_W-1:0] delay,
  output logic sel_out
);
  logic [DEPTH-1:0] tap_r;

  if (DEPTH < DLY_MAX + 1)
  begin : g_depth_chk
    $error("select_delay_line: DEPTH too small");
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tap_r <= '0;
    else
      tap_r <= {tap_r[DEPTH-2:0], sel_raw};
  end

  // Tap 0 is one cycle; delay only counts during a swap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_out <= 1'b0;
    else if (swap_active)
      sel_out <= (delay == '0) ? sel_raw : tap_r[delay - 5'd1];
    else
      sel_out <= sel_raw;
  end
endmodule : select_delay_line

// ### src/marker_inserter.sv
// Places the timestamp marker on the LSB of an N-bit transport sample
`timescale 1ns/1ps
module marker_inserter
  import swap_ctrl_pkg::*;
#(
  parameter int CONV_W = 12,
  parameter int N_W = 16
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [CONV_W-1:0] sample_in,
  input wire logic marker_in,
  input wire logic enable,
  output logic [N_W-1:0] sample_out
);
  if (N_W < CONV_W)
  begin : g_width_chk
    $error("marker_inserter: N_W below CONV_W");
  end

  logic [N_W-1:0] field;

  always_comb
  begin
    field = '0;
    field[N_W-1 -: CONV_W] = sample_in;
    if (enable)
      field[0] = marker_in;
  end

  // Same single register stage as the sample path keeps them aligned
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sample_out <= '0;
    else
      sample_out <= field;
  end
endmodule : marker_inserter

// ### tb/adc_swap_dither_timestamp_ctrl_test.sv
// Self-checking bench for the swap, dither, marker and link control registers
`timescale 1ns/1ps
module adc_swap_dither_timestamp_ctrl_test
  import swap_ctrl_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic swap_active = 1'b0;
  logic swap_sel_raw = 1'b0;
  core_pair_t core_data = '{core_a: 12'h5a3, core_b: 12'h0c6};
  logic marker_in = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [11:0] encoder_data;
  logic [15:0] transport_sample;
  dither_cfg_t dither_cfg;
  logic serial_link_subsystem_on;
  logic [1:0] ila_control_bits;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_checks = 0;

  adc_swap_dither_timestamp_ctrl #(.CONV_W(12), .N_W(16)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .swap_active(swap_active), .swap_sel_raw(swap_sel_raw), .core_data(core_data),
    .marker_in(marker_in), .encoder_data(encoder_data),
    .transport_sample(transport_sample), .dither_cfg(dither_cfg),
    .serial_link_subsystem_on(serial_link_subsystem_on),
    .ila_control_bits(ila_control_bits)
  );

  initial
  begin
    forever #5 hclk = ~hclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {18'h0, a, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk("hrdata", {24'h0, exp}, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rdchk

  task automatic chk_defaults;
    rdchk(OFF_SWAP_DLY, 8'h07);
    rdchk(OFF_DITHER, 8'h00);
    rdchk(OFF_MARKER, 8'h00);
    rdchk(OFF_LINK_EN, 8'h01);
    chk("link_on", 32'h1, {31'h0, serial_link_subsystem_on});
    chk("dither_cfg", 32'h0, {29'h0, dither_cfg});
  endtask : chk_defaults

  // Edges from raw select change until steered data follows
  task automatic sel_lat(input logic [7:0] d, input logic sw, input logic [31:0] exp);
    int n;
    xfer(1'b1, OFF_SWAP_DLY, d);
    swap_active <= sw;
    swap_sel_raw <= 1'b0;
    repeat (40) @(posedge hclk);
    chk("encoder_data", 32'h5a3, {20'h0, encoder_data});
    swap_sel_raw <= 1'b1;
    n = 0;
    do
    begin
      @(posedge hclk);
      #1;
      n++;
    end
    while (encoder_data !== 12'h0c6 && n < 60);
    chk("select latency", exp, n);
    if (n >= 60)
      print_verdict();
  endtask : sel_lat

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk_defaults();
    rdchk(12'h300, 8'h00);
    xfer(1'b1, OFF_SWAP_DLY, 8'h1f);
    rdchk(OFF_SWAP_DLY, 8'h1f);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, OFF_DITHER, 8'(i));
      repeat (2) @(posedge hclk);
      #1;
      chk("dither_cfg", {29'h0, i[0], i[1], i[2]}, {29'h0, dither_cfg});
      rdchk(OFF_DITHER, 8'(i));
    end
    sel_lat(8'h00, 1'b1, 32'd2);
    sel_lat(8'h05, 1'b1, 32'd7);
    sel_lat(8'h1f, 1'b1, 32'd33);
    sel_lat(8'h05, 1'b0, 32'd2);
    xfer(1'b1, OFF_MARKER, 8'h01);
    marker_in <= 1'b1;
    repeat (3) @(posedge hclk);
    #1;
    chk("transport", 32'h0c61, {16'h0, transport_sample});
    chk("ila_cs", 32'h0, {30'h0, ila_control_bits});
    rdchk(OFF_MARKER, 8'h01);
    xfer(1'b1, OFF_MARKER, 8'h00);
    repeat (3) @(posedge hclk);
    #1;
    chk("transport", 32'h0c60, {16'h0, transport_sample});
    xfer(1'b1, OFF_LINK_EN, 8'h00);
    repeat (2) @(posedge hclk);
    #1;
    chk("link_on", 32'h0, {31'h0, serial_link_subsystem_on});
    rdchk(OFF_LINK_EN, 8'h00);
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    chk_defaults();
    print_verdict();
  end
endmodule : adc_swap_dither_timestamp_ctrl_test
